/* File: swpc_ctrl.sv */
// Overview of operation
// R1 - running and quiescent states joined by controlled intermediate states
// R2 - sleep begins on control-register write or usb standby request
// R3 - requesters ask for sleep only while running
// R4 - wake begins on usb standby exit, pin, or timer
// R5 - wake stimuli act only while asleep, ignored while running
// R6 - wake seen during sleep entry is held until asleep
// R7 - running: all powered; asleep: node and peripherals powered down
// R8 - wake on pin change to software-chosen level
// R9 - wake when 64-bit counter reaches software compare value
// R10 - usb host wake brings controller out of sleep when usb enabled
// R11 - counter ticks once per main clock while running
// R12 - counter optionally moves to slow oscillator while asleep
// R13 - on slow ticks counter adds programmed increment
// R14 - 128-byte deep-sleep memory keeps contents while asleep
// R15 - power-good loss during transitions gives full system reset
// R16 - software should leave only second buck on, pfm, clock masked, reset
// R17 - software should stop crystal bias and oscillators before sleep
// R18 - watchdog enabled and clocked only while running
// R19 - wake reverses sleep order: supplies, then clock, then reset
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module swpc_ctrl
   import swpc_pkg::*;
#(
   parameter int unsigned STEP = STEP_CYC,
   parameter int unsigned PGW = PG_WAIT_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire swpc_avs_s avs_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [NSUP-1:0] pgood_i,
   input wire logic wake_pin_i,
   input wire logic slow_osc_i,
   input wire logic usb_sleep_i,
   input wire logic usb_wake_i,
   output swpc_pwr_s pwr_o,
   output logic wdog_en_o,
   output logic sys_reset_o,
   output logic asleep_o
);
   localparam int unsigned NIN = NSUP + 2;

   swpc_state_e state_reg, state_next;
   logic [15:0] cnt_reg, cnt_next;
   logic [NIN-1:0] s1_reg, s2_reg, s3_reg, in_reg;
   logic pin_q_reg, slow_q_reg, wake_pend_reg, wake_pend_next;
   logic ack_reg, sys_rst_reg;
   logic [31:0] rdata_reg, rd_mux, incr_reg, slp_reg;
   logic [4:0] cfg_reg;
   logic [63:0] cmp_reg, rtc_reg, rtc_next;
   swpc_pwr_s pwr_reg, pwr_next;

   // three-stage sync; level accepted once stages two and three agree
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= {slow_osc_i, wake_pin_i, pgood_i};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   for (genvar g = 0; g < NIN; g++) begin : g_agree
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) in_reg[g] <= 1'b0;
         else if (s2_reg[g] == s3_reg[g]) in_reg[g] <= s3_reg[g];
      end
   end

   wire logic [NSUP-1:0] pg = in_reg[NSUP-1:0];
   wire logic pin = in_reg[NSUP];
   wire logic slow = in_reg[NSUP+1];
   wire logic slow_rise = slow & ~slow_q_reg;

   // avalon slave: one wait cycle, write lands on the ack edge
   wire logic req = avs_i.read | avs_i.write;
   wire logic wr_go = avs_i.write & ack_reg;
   wire logic is_dsm = avs_i.address[A_DSM_BIT];
   wire logic [4:0] dsm_idx = avs_i.address[6:2];
   wire logic wr_reg = wr_go & ~is_dsm;
   wire logic [31:0] wd = avs_i.writedata;
   wire logic wr_ctrl = wr_reg & (avs_i.address == A_CTRL);
   wire logic rtc_wr = wr_reg & ((avs_i.address == A_RTC_LO) | (avs_i.address == A_RTC_HI));
   assign avs_waitrequest_o = req & ~ack_reg;

   // deep-sleep store has no reset so contents survive every state
   wire logic [31:0] dsm_rd;
   for (genvar b = 0; b < 4; b++) begin : g_lane
      logic [7:0] mem [DSM_WORDS];
      always_ff @(posedge clk_i) begin
         if (wr_go & is_dsm & avs_i.byteenable[b]) mem[dsm_idx] <= wd[b*8 +: 8]; // R14
      end
      assign dsm_rd[b*8 +: 8] = mem[dsm_idx];
   end

   always_comb begin
      case (avs_i.address)
         A_CTRL: rd_mux = 32'h0;
         A_CFG: rd_mux = {27'h0, cfg_reg};
         A_STAT: rd_mux = {28'h0, wake_pend_reg, state_reg};
         A_CMP_LO: rd_mux = cmp_reg[31:0];
         A_CMP_HI: rd_mux = cmp_reg[63:32];
         A_RTC_LO: rd_mux = rtc_reg[31:0];
         A_RTC_HI: rd_mux = rtc_reg[63:32];
         A_INCR: rd_mux = incr_reg;
         A_SLP: rd_mux = slp_reg;
         default: rd_mux = is_dsm ? dsm_rd : 32'h0;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0;
      end else begin
         ack_reg <= req & ~ack_reg;
         if (avs_i.read & ~ack_reg) rdata_reg <= rd_mux;
      end
   end
   assign avs_readdata_o = rdata_reg;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cfg_reg <= CFG_RST_VAL;
         slp_reg <= SLP_RST_VAL;
         incr_reg <= INCR_RST_VAL;
         cmp_reg <= CMP_RST_VAL;
      end else if (wr_reg) begin
         if (avs_i.address == A_CFG) cfg_reg <= wd[4:0];
         if (avs_i.address == A_SLP) slp_reg <= wd;
         if (avs_i.address == A_INCR) incr_reg <= wd;
         if (avs_i.address == A_CMP_LO) cmp_reg[31:0] <= wd;
         if (avs_i.address == A_CMP_HI) cmp_reg[63:32] <= wd;
      end
   end

   // wake sources and sleep requests
   wire logic awake = state_reg == ST_AWAKE;
   wire logic in_asleep = state_reg == ST_ASLEEP;
   wire logic sleep_req = awake & (usb_sleep_i | (wr_ctrl & wd[CTRL_SLEEP])); // R2 R3
   wire logic pin_ev = cfg_reg[CFG_PIN_EN] & (pin != pin_q_reg) & (pin == cfg_reg[CFG_PIN_POL]); // R8
   wire logic timer_hit = cfg_reg[CFG_TMR_EN] & (rtc_reg >= cmp_reg); // R9
   wire logic usb_ev = cfg_reg[CFG_USB_EN] & usb_wake_i; // R10
   wire logic wake_ev = pin_ev | timer_hit | usb_ev; // R4
   // held through sleep entry, dropped while running
   assign wake_pend_next = ~awake & (wake_ev | (wake_pend_reg & ~in_asleep)); // R5 R6

   // power-good watch over every transitional state
   wire logic in_trans = ~awake & ~in_asleep;
   wire logic done = cnt_reg == 16'h0;
   wire logic pg_ok = &(pg | ~pwr_reg.sup_en);
   wire logic pg_fail = in_trans & ((state_reg == ST_W_PWR) ? (done & ~pg_ok) : ~pg_ok); // R15

   always_comb begin
      state_next = state_reg;
      cnt_next = done ? cnt_reg : cnt_reg - 16'h1;
      case (state_reg)
         ST_AWAKE: if (sleep_req) begin
            state_next = ST_S_RST;
            cnt_next = 16'(STEP);
         end
         ST_S_RST: if (done) begin
            state_next = ST_S_CLK;
            cnt_next = 16'(STEP);
         end
         ST_S_CLK: if (done) begin
            state_next = ST_S_PWR;
            cnt_next = 16'(STEP);
         end
         ST_S_PWR: if (done) state_next = ST_ASLEEP;
         ST_ASLEEP: if (wake_pend_reg) begin // R6
            state_next = ST_W_PWR;
            cnt_next = 16'(PGW);
         end
         ST_W_PWR: if (pg_ok) begin // R19
            state_next = ST_W_CLK;
            cnt_next = 16'(STEP);
         end
         ST_W_CLK: if (done) begin
            state_next = ST_W_RST;
            cnt_next = 16'(STEP);
         end
         ST_W_RST: if (done) state_next = ST_AWAKE;
         default: state_next = ST_AWAKE;
      endcase
      if (pg_fail) state_next = ST_AWAKE; // R15
   end

   // outputs follow the sleep settings; reset first on the way down, last up
   wire logic low_pwr = (state_next == ST_S_PWR) | (state_next == ST_ASLEEP); // R7
   wire logic clk_off = low_pwr | (state_next == ST_S_CLK) | (state_next == ST_W_PWR); // R19
   always_comb begin
      pwr_next.core_rst = slp_reg[SLP_RST] & (state_next != ST_AWAKE); // R1 R19
      pwr_next.clk_mask = slp_reg[SLP_CLK] & clk_off;
      pwr_next.sup_en = low_pwr ? ~slp_reg[SLP_DIS +: NSUP] : {NSUP{1'b1}}; // R7
      pwr_next.sup_pfm = low_pwr ? {NSUP{slp_reg[SLP_PFM]}} : {NSUP{1'b0}};
   end

   // counter: main tick while running, scaled slow tick when asleep and chosen
   wire logic slow_mode = in_asleep & cfg_reg[CFG_AUTO_SLOW]; // R12
   always_comb begin
      if (slow_mode) rtc_next = slow_rise ? rtc_reg + 64'(incr_reg) : rtc_reg; // R13
      else rtc_next = rtc_reg + 64'h1; // R11
      if (rtc_wr & (avs_i.address == A_RTC_LO)) rtc_next[31:0] = wd;
      if (rtc_wr & (avs_i.address == A_RTC_HI)) rtc_next[63:32] = wd;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_reg <= ST_AWAKE;
         cnt_reg <= 16'h0;
         wake_pend_reg <= 1'b0;
         pin_q_reg <= 1'b0;
         slow_q_reg <= 1'b0;
         rtc_reg <= 64'h0;
         pwr_reg <= '{core_rst: 1'b0, clk_mask: 1'b0, sup_en: {NSUP{1'b1}}, sup_pfm: {NSUP{1'b0}}};
         sys_rst_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         wake_pend_reg <= wake_pend_next;
         pin_q_reg <= pin;
         slow_q_reg <= slow;
         rtc_reg <= rtc_next;
         pwr_reg <= pwr_next;
         sys_rst_reg <= pg_fail;
      end
   end

   assign pwr_o = pwr_reg;
   assign sys_reset_o = sys_rst_reg;
   assign asleep_o = in_asleep;
   // watchdog runs only while fully awake
   assign wdog_en_o = awake; // R18

   // checks
   sequence sleep_start_s;
      state_reg == ST_S_RST ##1 state_reg == ST_S_RST;
   endsequence
   sequence wake_start_s;
      state_reg == ST_W_PWR && pwr_reg.sup_en == {NSUP{1'b1}};
   endsequence
   sequence mask_s;
      state_reg == ST_S_RST ##1 state_reg == ST_S_CLK;
   endsequence
   sequence unmask_s;
      state_reg == ST_W_PWR ##1 state_reg == ST_W_CLK;
   endsequence

   sleep_entry_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R2
      sleep_req |=> sleep_start_s)
      else $error("sleep request did not start entry sequence");
   awake_ignore_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R5
      awake && wake_ev && !sleep_req |=> state_reg == ST_AWAKE && !wake_pend_reg)
      else $error("wake stimulus acted while running");
   pend_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R6
      in_asleep && wake_pend_reg |=> wake_start_s)
      else $error("held wake did not start wake sequence");
   pin_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R8
      in_asleep && pin_ev |-> ##2 state_reg == ST_W_PWR)
      else $error("pin wake not taken");
   timer_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R9
      in_asleep && timer_hit |-> ##2 state_reg == ST_W_PWR)
      else $error("timer wake not taken");
   usb_wake_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
      in_asleep && usb_ev |-> ##2 state_reg == ST_W_PWR)
      else $error("usb wake not taken");
   rtc_tick_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
      awake && !rtc_wr |=> rtc_reg == $past(rtc_reg) + 64'h1)
      else $error("counter missed main tick");
   rtc_slow_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R13
      slow_mode && !rtc_wr |=> rtc_reg == $past(rtc_reg) + ($past(slow_rise) ? 64'($past(incr_reg)) : 64'h0))
      else $error("slow tick increment wrong");
   pg_reset_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R15
      pg_fail |=> sys_reset_o && state_reg == ST_AWAKE && !pwr_reg.core_rst)
      else $error("power-good loss did not reset");
   wdog_stop_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R18
      sleep_req |=> !wdog_en_o [*2])
      else $error("watchdog still enabled after sleep start");
   wake_order_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R19
      $fell(pwr_reg.clk_mask) && !sys_reset_o |-> pwr_reg.sup_en == {NSUP{1'b1}} && !$fell(pwr_reg.core_rst))
      else $error("clock unmasked before supplies or with reset");
   sleep_steps_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R1
      mask_s |-> pwr_reg.core_rst == slp_reg[SLP_RST] && pwr_reg.clk_mask == slp_reg[SLP_CLK]
         && pwr_reg.sup_en == {NSUP{1'b1}})
      else $error("sleep steps out of order");
   wake_unmask_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R19
      unmask_s |-> !pwr_reg.clk_mask && pwr_reg.core_rst == slp_reg[SLP_RST]
         && pwr_reg.sup_en == {NSUP{1'b1}})
      else $error("clock not unmasked after supplies restored");
   reset_release_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R19
      $fell(pwr_reg.core_rst) && !sys_reset_o |-> awake && !pwr_reg.clk_mask
         && pwr_reg.sup_en == {NSUP{1'b1}})
      else $error("reset released before clock and supplies");
   asleep_pwr_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // R7
      in_asleep |-> pwr_reg.sup_en == ~slp_reg[SLP_DIS +: NSUP])
      else $error("supplies not at sleep setting");
endmodule : swpc_ctrl
`default_nettype wire

/* File: swpc_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module swpc_partner
   import swpc_pkg::*;
(
   input wire logic clk_i,
   input wire logic awake_i,
   input wire logic [NSUP-1:0] sup_en_i,
   input wire logic [NSUP-1:0] fail_i,
   input wire logic sleep_req_i,
   input wire logic wake_req_i,
   output logic [NSUP-1:0] pgood_o,
   output logic usb_sleep_o,
   output logic usb_wake_o
);
   logic [NSUP-1:0] pg_q;
   // two-cycle lag: a supply is never good the instant it is enabled
   always @(posedge clk_i) begin
      pg_q <= sup_en_i & ~fail_i;
      pgood_o <= pg_q;
   end
   // standby entry asked only while running, exit only while not
   always @(posedge clk_i) begin
      usb_sleep_o <= sleep_req_i & awake_i;
      usb_wake_o <= wake_req_i & ~awake_i;
   end
endmodule : swpc_partner
`default_nettype wire

/* File: swpc_pkg.sv */
package swpc_pkg;
   localparam int unsigned NSUP = 2;
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned STEP_NS = 100;
   localparam int unsigned STEP_CYC = (STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned PG_WAIT_NS = 20000;
   localparam int unsigned PG_WAIT_CYC = PG_WAIT_NS * CLK_MHZ / 1000;
   localparam int unsigned DSM_BYTES = 128;
   localparam int unsigned DSM_WORDS = DSM_BYTES / 4;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_CFG = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_CMP_LO = 8'h0c;
   localparam logic [7:0] A_CMP_HI = 8'h10;
   localparam logic [7:0] A_RTC_LO = 8'h14;
   localparam logic [7:0] A_RTC_HI = 8'h18;
   localparam logic [7:0] A_INCR = 8'h1c;
   localparam logic [7:0] A_SLP = 8'h20;
   localparam int unsigned A_DSM_BIT = 7;
   localparam int unsigned CTRL_SLEEP = 0;
   localparam int unsigned CFG_PIN_EN = 0;
   localparam int unsigned CFG_PIN_POL = 1;
   localparam int unsigned CFG_TMR_EN = 2;
   localparam int unsigned CFG_USB_EN = 3;
   localparam int unsigned CFG_AUTO_SLOW = 4;
   localparam int unsigned SLP_RST = 0;
   localparam int unsigned SLP_CLK = 1;
   localparam int unsigned SLP_PFM = 2;
   localparam int unsigned SLP_DIS = 8;
   localparam logic [4:0] CFG_RST_VAL = 5'h00;
   localparam logic [31:0] SLP_RST_VAL = 32'h0000_0000;
   localparam logic [31:0] INCR_RST_VAL = 32'h0000_0c80;
   localparam logic [63:0] CMP_RST_VAL = 64'hffff_ffff_ffff_ffff;
   typedef enum logic [2:0] {
      ST_AWAKE, ST_S_RST, ST_S_CLK, ST_S_PWR, ST_ASLEEP, ST_W_PWR, ST_W_CLK, ST_W_RST
   } swpc_state_e;
   typedef struct packed {
      logic core_rst;
      logic clk_mask;
      logic [NSUP-1:0] sup_en;
      logic [NSUP-1:0] sup_pfm;
   } swpc_pwr_s;
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } swpc_avs_s;
endpackage : swpc_pkg

/* File: test_swpc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module test_swpc_ctrl
   import swpc_pkg::*;
;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   swpc_avs_s avs = '0;
   logic [31:0] rdata;
   logic wreq;
   logic [NSUP-1:0] pgood;
   logic wake_pin = 1'b0;
   logic slow_osc = 1'b0;
   logic usb_sleep;
   logic usb_wake;
   logic sleep_req = 1'b0;
   logic wake_req = 1'b0;
   logic [NSUP-1:0] fail = '0;
   swpc_pwr_s pwr;
   logic wdog_en;
   logic sys_reset;
   logic asleep;
   logic [31:0] rd;
   logic [31:0] rd2;
   int fail_count = 0;
   int check_count = 0;
   always #5 clk_i = ~clk_i;
   swpc_ctrl #(.STEP(4), .PGW(50)) DUT (.clk_i(clk_i), .nrst_i(nrst_i), .avs_i(avs), .avs_readdata_o(rdata),
      .avs_waitrequest_o(wreq), .pgood_i(pgood), .wake_pin_i(wake_pin), .slow_osc_i(slow_osc),
      .usb_sleep_i(usb_sleep), .usb_wake_i(usb_wake), .pwr_o(pwr), .wdog_en_o(wdog_en),
      .sys_reset_o(sys_reset), .asleep_o(asleep));
   swpc_partner far_end (.clk_i(clk_i), .awake_i(wdog_en), .sup_en_i(pwr.sup_en), .fail_i(fail),
      .sleep_req_i(sleep_req), .wake_req_i(wake_req), .pgood_o(pgood), .usb_sleep_o(usb_sleep),
      .usb_wake_o(usb_wake));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      logic ws;
      ws = 1'b1;
      @(posedge clk_i);
      avs <= '{address: a, read: ~wr, write: wr, byteenable: 4'hf, writedata: d};
      // values read at an edge are those standing just before it
      for (n = 0; n < 20 && ws !== 1'b0; n++) begin
         @(posedge clk_i);
         ws = wreq;
         q = rdata;
      end
      avs <= '0;
      check("bus answer", 0, ws);
      if (ws !== 1'b0) give_verdict();
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic wait_for(input string what, ref logic sig, input logic lvl);
      int n;
      for (n = 0; n < 400 && sig !== lvl; n++) @(posedge clk_i);
      check(what, lvl, sig);
      if (sig !== lvl) give_verdict();
   endtask : wait_for
   task automatic slow_ticks(input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_i);
         slow_osc <= 1'b1;
         repeat (4) @(posedge clk_i);
         slow_osc <= 1'b0;
      end
   endtask : slow_ticks
   task automatic t_reset();
      check("pwr at reset", 6'b001100, pwr);
      check("wdog at reset", 1, wdog_en);
      bus(1'b0, A_INCR, 0, rd);
      check("incr reset", INCR_RST_VAL, rd);
      bus(1'b0, A_CMP_HI, 0, rd);
      check("cmp hi reset", CMP_RST_VAL[63:32], rd);
      bus(1'b0, 8'h40, 0, rd);
      check("unmapped read", 0, rd);
      $display("test reset done");
   endtask : t_reset
   task automatic t_usb();
      wr(8'h80, 32'h5a5a_1234);
      wr(A_SLP, 32'h0000_0107);
      wr(A_CFG, 32'h0000_0008);
      sleep_req <= 1'b1;
      @(posedge clk_i);
      sleep_req <= 1'b0;
      wait_for("asleep by usb", asleep, 1'b1);
      check("pwr asleep", 6'b111011, pwr);
      check("wdog asleep", 0, wdog_en);
      wake_req <= 1'b1;
      wait_for("usb wake", asleep, 1'b0);
      wake_req <= 1'b0;
      check("supplies first", 4'b1111, {pwr.core_rst, pwr.clk_mask, pwr.sup_en});
      wait_for("awake after usb", wdog_en, 1'b1);
      check("pwr awake", 6'b001100, pwr);
      bus(1'b0, 8'h80, 0, rd);
      check("sleep store kept", 32'h5a5a_1234, rd);
      $display("test usb done");
   endtask : t_usb
   task automatic t_pin();
      for (int p = 0; p < 2; p++) begin
         wake_pin <= ~p[0];
         wr(A_CFG, {30'h0, p[0], 1'b1});
         wr(A_CTRL, 32'h0000_0001);
         if (p == 0) wake_pin <= p[0];
         wait_for("asleep despite early pin", asleep, 1'b1);
         if (p == 1) wake_pin <= p[0];
         wait_for("pin wake", asleep, 1'b0);
         wait_for("awake after pin", wdog_en, 1'b1);
      end
      $display("test pin done");
   endtask : t_pin
   task automatic t_ignore();
      wake_pin <= 1'b0;
      wr(A_CFG, 32'h0000_0003);
      wake_pin <= 1'b1;
      repeat (30) @(posedge clk_i);
      bus(1'b0, A_STAT, 0, rd);
      check("no wake while running", 0, rd[3:0]);
      wake_pin <= 1'b0;
      $display("test ignore done");
   endtask : t_ignore
   task automatic t_timer();
      bus(1'b0, A_RTC_LO, 0, rd);
      bus(1'b0, A_RTC_LO, 0, rd2);
      check("rtc per clock", 3, rd2 - rd);
      wr(A_INCR, 32'h0000_0100);
      wr(A_RTC_LO, 0);
      wr(A_RTC_HI, 0);
      wr(A_CMP_HI, 0);
      wr(A_CMP_LO, 32'h0000_0800);
      wr(A_CFG, 32'h0000_0014);
      wr(A_CTRL, 32'h0000_0001);
      wait_for("asleep for timer", asleep, 1'b1);
      bus(1'b0, A_RTC_LO, 0, rd);
      slow_ticks(3);
      bus(1'b0, A_RTC_LO, 0, rd2);
      check("slow increment", 32'h0000_0300, rd2 - rd);
      check("still asleep", 1, asleep);
      slow_ticks(6);
      wait_for("timer wake", asleep, 1'b0);
      wait_for("awake after timer", wdog_en, 1'b1);
      wr(A_CMP_HI, 32'hffff_ffff);
      $display("test timer done");
   endtask : t_timer
   task automatic t_pgfail();
      wr(A_CFG, 0);
      wr(A_CTRL, 32'h0000_0001);
      fail <= 2'b10;
      wait_for("reset on power loss", sys_reset, 1'b1);
      wait_for("back to running", wdog_en, 1'b1);
      repeat (2) @(posedge clk_i);
      check("pwr after fail", 6'b001100, pwr);
      fail <= 2'b00;
      repeat (8) @(posedge clk_i);
      $display("test power fail done");
   endtask : t_pgfail
   initial begin
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      t_reset();
      t_usb();
      t_pin();
      t_ignore();
      t_timer();
      t_pgfail();
      give_verdict();
   end
endmodule : test_swpc_ctrl
`default_nettype wire
